// ### verilog/dsd_encoder.sv
// Behaviour
// - Ready, no warning: green flashes, red dark
// - Running with warning: green steady, red flashes
// - Ready with warning: both indicators flash
// - Fault awaiting acknowledge: green off, red steady
// - Init both steady; run green; last-fault red flashes
// - Panel mirrors run, warn, fault patterns
// - Signal n sits at bit n-1
// - Six inputs plus digital multifunction input
// - Two outputs plus digital multifunction output
// - Controller code is OR of active bits
// - Codes 0001, 0002, 0004, 0008 for DC functions
// - Codes 0010, 0020, 0040 boost, current, torque
// - Code 0080 control method switch-over
// - Codes 0100, 0200, 0400 start and overload
// - Codes 0800, 1000, 2000 temperatures, frequency
// - Setting selects controller status display
// - Keep snapshots of four latest faults
// - Snapshot holds elapsed time since enable
// - Snapshot holds controller and warning codes
// - Flag reports snapshot stored complete or not
module dsd_encoder #(
  parameter int FLASH_CYC = dsd_pkg::DSD_FLASH_CYC,
  parameter int MS_CYC    = dsd_pkg::DSD_MS_CYC
) (
  input  wire logic                        sys_clk,
  input  wire logic                        rst_b,
  input  wire dsd_pkg::dsd_opstate_e       op_state,
  input  wire logic                        warn_present,
  input  wire logic                        panel_attached,
  input  wire logic [1:0]                  ctrl_status_mode,
  input  wire dsd_pkg::dsd_limit_s         limits,
  input  wire logic [dsd_pkg::DSD_DIN_N-1:0]  din_level,
  input  wire logic                        multifunction_input_one,
  input  wire logic                        mfi_digital_mode,
  input  wire logic [dsd_pkg::DSD_DOUT_N-1:0] dout_level,
  input  wire logic                        multifunction_output_one,
  input  wire logic                        mfo_digital_mode,
  input  wire logic                        release_en,
  input  wire logic [15:0]                 warn_status,
  input  wire logic                        fault_event,
  input  wire logic                        store_abort,
  input  wire logic [1:0]                  snap_sel,
  output logic                             led_green,
  output logic                             led_red,
  output dsd_pkg::dsd_panel_s              panel,
  output logic [15:0]                      ctrl_status_led,
  output logic [15:0]                      ctrl_status_panel,
  output logic [6:0]                       din_status,
  output logic [2:0]                       dout_status,
  output logic [15:0]                      ctrl_status,
  output dsd_pkg::dsd_snap_s               snap_out,
  output logic                             snap_ok
);

  // ==========================================================================
  // Flash timebase
  logic [31:0] flash_cnt_r, flash_cnt_nxt;
  logic        flash_r, flash_nxt;

  always_comb begin
    flash_cnt_nxt = flash_cnt_r + 32'h1;
    flash_nxt     = flash_r;
    if (flash_cnt_r >= 32'(FLASH_CYC - 1)) begin
      flash_cnt_nxt = 32'h0;
      flash_nxt     = ~flash_r;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      flash_cnt_r <= 32'h0;
      flash_r     <= 1'b0;
    end else begin
      flash_cnt_r <= flash_cnt_nxt;
      flash_r     <= flash_nxt;
    end
  end

  function automatic logic pat_level(dsd_pkg::dsd_pat_e p, logic fl);
    unique case (p)
      dsd_pkg::DSD_PAT_OFF:   pat_level = 1'b0;
      dsd_pkg::DSD_PAT_ON:    pat_level = 1'b1;
      default:                pat_level = fl;
    endcase
  endfunction

  // ==========================================================================
  // Indicator patterns
  dsd_pkg::dsd_pat_e g_pat, r_pat, run_pat, warn_pat, flt_pat;

  always_comb begin
    g_pat    = dsd_pkg::DSD_PAT_OFF;
    r_pat    = dsd_pkg::DSD_PAT_OFF;
    run_pat  = dsd_pkg::DSD_PAT_OFF;
    warn_pat = dsd_pkg::DSD_PAT_OFF;
    flt_pat  = dsd_pkg::DSD_PAT_OFF;
    unique case (op_state)
      dsd_pkg::DSD_OFF: begin
      end
      dsd_pkg::DSD_INIT: begin
        g_pat = dsd_pkg::DSD_PAT_ON;
        r_pat = dsd_pkg::DSD_PAT_ON;
      end
      dsd_pkg::DSD_READY: begin
        g_pat = dsd_pkg::DSD_PAT_FLASH;
        if (warn_present) begin
          r_pat    = dsd_pkg::DSD_PAT_FLASH;
          run_pat  = dsd_pkg::DSD_PAT_ON;
          warn_pat = dsd_pkg::DSD_PAT_ON;
        end else begin
          run_pat  = dsd_pkg::DSD_PAT_FLASH;
        end
      end
      dsd_pkg::DSD_RUN: begin
        g_pat   = dsd_pkg::DSD_PAT_ON;
        run_pat = dsd_pkg::DSD_PAT_ON;
        if (warn_present) begin
          r_pat    = dsd_pkg::DSD_PAT_FLASH;
          warn_pat = dsd_pkg::DSD_PAT_ON;
        end
      end
      dsd_pkg::DSD_FAULT_LAST: begin
        r_pat   = dsd_pkg::DSD_PAT_FLASH;
        flt_pat = dsd_pkg::DSD_PAT_FLASH;
      end
      default: begin
        r_pat   = dsd_pkg::DSD_PAT_ON;
        flt_pat = dsd_pkg::DSD_PAT_ON;
      end
    endcase
  end

  // ==========================================================================
  // Status encoding
  logic [15:0] cs_nxt;
  logic [6:0]  din_nxt;
  logic [2:0]  dout_nxt;

  always_comb begin
    cs_nxt = 16'h0;
    if (limits.dc_ctrl_rise_phase)       cs_nxt = cs_nxt | dsd_pkg::DSD_CS_DC_RISE;
    if (limits.below_shutdown_threshold) cs_nxt = cs_nxt | dsd_pkg::DSD_CS_SHUTDOWN;
    if (limits.mains_fail_regulation)    cs_nxt = cs_nxt | dsd_pkg::DSD_CS_MAINS;
    if (limits.dc_link_overvolt_limit)   cs_nxt = cs_nxt | dsd_pkg::DSD_CS_OVERVOLT;
    if (limits.boost)                    cs_nxt = cs_nxt | dsd_pkg::DSD_CS_BOOST;
    if (limits.current_limit)            cs_nxt = cs_nxt | dsd_pkg::DSD_CS_CUR_LIM;
    if (limits.torque_limit)             cs_nxt = cs_nxt | dsd_pkg::DSD_CS_TRQ_LIM;
    if (limits.ctrl_switch)              cs_nxt = cs_nxt | dsd_pkg::DSD_CS_CTRL_SW;
    if (limits.start_limit)              cs_nxt = cs_nxt | dsd_pkg::DSD_CS_START_LIM;
    if (limits.long_overload_limit)      cs_nxt = cs_nxt | dsd_pkg::DSD_CS_LONG_OVL;
    if (limits.short_overload_limit)     cs_nxt = cs_nxt | dsd_pkg::DSD_CS_SHORT_OVL;
    if (limits.heatsink_limit)           cs_nxt = cs_nxt | dsd_pkg::DSD_CS_HEATSINK;
    if (limits.motor_temp_limit)         cs_nxt = cs_nxt | dsd_pkg::DSD_CS_MOTOR_TMP;
    if (limits.freq_limit)               cs_nxt = cs_nxt | dsd_pkg::DSD_CS_FREQ_LIM;
    // Signal n lands on bit n-1; multifunction pin is the next bit up
    din_nxt  = {multifunction_input_one & mfi_digital_mode, din_level};
    dout_nxt = {multifunction_output_one & mfo_digital_mode, dout_level};
  end

  // Digital levels come from the same clock domain, so no synchroniser
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_status <= 16'h0;
      din_status  <= 7'h0;
      dout_status <= 3'h0;
      led_green   <= 1'b0;
      led_red     <= 1'b0;
      panel       <= '0;
    end else begin
      ctrl_status <= cs_nxt;
      din_status  <= din_nxt;
      dout_status <= dout_nxt;
      led_green   <= pat_level(g_pat, flash_r);
      led_red     <= pat_level(r_pat, flash_r);
      panel.run   <= panel_attached & pat_level(run_pat, flash_r);
      panel.warn  <= panel_attached & pat_level(warn_pat, flash_r);
      panel.fault <= panel_attached & pat_level(flt_pat, flash_r);
    end
  end

  // Display routing is combinational off the registered code
  always_comb begin
    ctrl_status_led   = ctrl_status_mode[1] ? ctrl_status : 16'h0;
    ctrl_status_panel = (ctrl_status_mode[0] & panel_attached) ? ctrl_status : 16'h0;
  end

  // ==========================================================================
  // Elapsed time since release
  dsd_pkg::dsd_time_s tm_r, tm_nxt;
  logic [31:0]        ms_cnt_r, ms_cnt_nxt;

  always_comb begin
    tm_nxt     = tm_r;
    ms_cnt_nxt = ms_cnt_r + 32'h1;
    if (!release_en) begin
      tm_nxt     = '0;
      ms_cnt_nxt = 32'h0;
    end else if (ms_cnt_r >= 32'(MS_CYC - 1)) begin
      ms_cnt_nxt = 32'h0;
      if (tm_r.millis != dsd_pkg::DSD_MS_MAX) tm_nxt.millis = tm_r.millis + 10'h1;
      else begin
        tm_nxt.millis = 10'h0;
        if (tm_r.seconds != dsd_pkg::DSD_SEC_MAX) tm_nxt.seconds = tm_r.seconds + 6'h1;
        else begin
          tm_nxt.seconds = 6'h0;
          if (tm_r.minutes != dsd_pkg::DSD_MIN_MAX) tm_nxt.minutes = tm_r.minutes + 6'h1;
          else begin
            tm_nxt.minutes = 6'h0;
            // Hours saturate at the five-digit limit instead of wrapping
            if (tm_r.hours != dsd_pkg::DSD_HR_MAX) tm_nxt.hours = tm_r.hours + 17'h1;
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tm_r     <= '0;
      ms_cnt_r <= 32'h0;
    end else begin
      tm_r     <= tm_nxt;
      ms_cnt_r <= ms_cnt_nxt;
    end
  end

  // ==========================================================================
  // Fault snapshots, newest in slot 0
  dsd_pkg::dsd_snap_s snap_r [dsd_pkg::DSD_SNAP_N];
  dsd_pkg::dsd_snap_s snap_nxt [dsd_pkg::DSD_SNAP_N];
  logic               ok_r, ok_nxt;

  always_comb begin
    snap_nxt = snap_r;
    ok_nxt   = ok_r;
    if (fault_event) begin
      for (int i = dsd_pkg::DSD_SNAP_N - 1; i > 0; i--) begin
        snap_nxt[i] = snap_r[i-1];
      end
      snap_nxt[0].elapsed     = tm_r;
      snap_nxt[0].ctrl_status = ctrl_status;
      snap_nxt[0].warn_status = warn_status;
      snap_nxt[0].valid       = ~store_abort;
      ok_nxt                  = ~store_abort;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < dsd_pkg::DSD_SNAP_N; i++) snap_r[i] <= '0;
      ok_r <= 1'b1;
    end else begin
      snap_r <= snap_nxt;
      ok_r   <= ok_nxt;
    end
  end

  always_comb begin
    snap_out = snap_r[snap_sel];
    snap_ok  = ok_r;
  end

  // ==========================================================================
  // Checks
  sequence s_fault_in;
    fault_event ##0 !store_abort;
  endsequence

  // Cut store must never pass for a complete one
  sequence s_fault_cut;
    fault_event ##0 store_abort;
  endsequence

  a_fault_red_on: assert property (@(posedge sys_clk) disable iff (!rst_b)
    op_state == dsd_pkg::DSD_FAULT_ACK |=> led_red && !led_green)
    else $error("fault state must show red steady");
  a_init_both_on: assert property (@(posedge sys_clk) disable iff (!rst_b)
    op_state == dsd_pkg::DSD_INIT |=> led_red && led_green)
    else $error("init must light both");
  a_ready_red_dark: assert property (@(posedge sys_clk) disable iff (!rst_b)
    op_state == dsd_pkg::DSD_READY && !warn_present |=> !led_red && led_green == $past(flash_r))
    else $error("ready must flash green only");
  a_run_warn_led: assert property (@(posedge sys_clk) disable iff (!rst_b)
    op_state == dsd_pkg::DSD_RUN && warn_present |=> led_green && led_red == $past(flash_r))
    else $error("run warning pattern wrong");
  a_ready_warn_led: assert property (@(posedge sys_clk) disable iff (!rst_b)
    op_state == dsd_pkg::DSD_READY && warn_present |=>
      led_green == $past(flash_r) && led_red == $past(flash_r))
    else $error("ready warning pattern wrong");
  a_last_fault_led: assert property (@(posedge sys_clk) disable iff (!rst_b)
    op_state == dsd_pkg::DSD_FAULT_LAST |=> !led_green && led_red == $past(flash_r))
    else $error("last fault pattern wrong");
  a_panel_detached: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !panel_attached |=> panel == '0)
    else $error("panel driven while detached");
  a_din_bit_map: assert property (@(posedge sys_clk) disable iff (!rst_b)
    1'b1 |=> din_status[5:0] == $past(din_level))
    else $error("input bit map wrong");
  a_mfi_gate: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !mfi_digital_mode |=> !din_status[6])
    else $error("analog input leaked into status");
  a_mfo_gate: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !mfo_digital_mode |=> !dout_status[2])
    else $error("analog output leaked into status");
  a_cs_overvolt: assert property (@(posedge sys_clk) disable iff (!rst_b)
    limits.dc_link_overvolt_limit |=> ctrl_status[3])
    else $error("overvoltage code missing");
  a_cs_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
    limits == '0 |=> ctrl_status == 16'h0)
    else $error("idle code not zero");
  a_snap_ctrl: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_fault_in |=> snap_r[0].ctrl_status == $past(ctrl_status) && snap_ok)
    else $error("snapshot capture wrong");
  a_snap_cut: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_fault_cut |=> !snap_ok && !snap_r[0].valid)
    else $error("cut store not flagged");
  a_snap_shift: assert property (@(posedge sys_clk) disable iff (!rst_b)
    fault_event |=> snap_r[1] == $past(snap_r[0]))
    else $error("snapshot history not shifted");
  a_timer_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !release_en |=> tm_r == '0)
    else $error("elapsed time not cleared");

endmodule // dsd_encoder

// ### verilog/dsd_pkg.sv
package dsd_pkg;

  // ==========================================================================
  // Operating state and indicator patterns
  typedef enum logic [2:0] {
    DSD_OFF,
    DSD_INIT,
    DSD_READY,
    DSD_RUN,
    DSD_FAULT_LAST,
    DSD_FAULT_ACK
  } dsd_opstate_e;

  typedef enum logic [1:0] {
    DSD_PAT_OFF,
    DSD_PAT_ON,
    DSD_PAT_FLASH
  } dsd_pat_e;

  // ==========================================================================
  // Controller status code bits
  localparam int DSD_CS_W = 16;
  localparam logic [15:0] DSD_CS_DC_RISE   = 16'h0001;
  localparam logic [15:0] DSD_CS_SHUTDOWN  = 16'h0002;
  localparam logic [15:0] DSD_CS_MAINS     = 16'h0004;
  localparam logic [15:0] DSD_CS_OVERVOLT  = 16'h0008;
  localparam logic [15:0] DSD_CS_BOOST     = 16'h0010;
  localparam logic [15:0] DSD_CS_CUR_LIM   = 16'h0020;
  localparam logic [15:0] DSD_CS_TRQ_LIM   = 16'h0040;
  localparam logic [15:0] DSD_CS_CTRL_SW   = 16'h0080;
  localparam logic [15:0] DSD_CS_START_LIM = 16'h0100;
  localparam logic [15:0] DSD_CS_LONG_OVL  = 16'h0200;
  localparam logic [15:0] DSD_CS_SHORT_OVL = 16'h0400;
  localparam logic [15:0] DSD_CS_HEATSINK  = 16'h0800;
  localparam logic [15:0] DSD_CS_MOTOR_TMP = 16'h1000;
  localparam logic [15:0] DSD_CS_FREQ_LIM  = 16'h2000;

  // Controller status display modes
  localparam logic [1:0] DSD_CSM_OFF   = 2'h0;
  localparam logic [1:0] DSD_CSM_PANEL = 2'h1;
  localparam logic [1:0] DSD_CSM_LED   = 2'h2;
  localparam logic [1:0] DSD_CSM_BOTH  = 2'h3;

  // ==========================================================================
  // Digital signal widths and timing
  localparam int DSD_DIN_N  = 6;
  localparam int DSD_DOUT_N = 2;
  localparam int DSD_FLASH_HALF_MS = 250;
  localparam int DSD_CLK_MHZ = 200;
  localparam int DSD_FLASH_CYC = DSD_FLASH_HALF_MS * 1000 * DSD_CLK_MHZ;
  localparam int DSD_MS_US = 1000;
  localparam int DSD_MS_CYC = DSD_MS_US * DSD_CLK_MHZ;

  // Snapshot format limits
  localparam logic [9:0]  DSD_MS_MAX  = 10'h3e7;
  localparam logic [5:0]  DSD_SEC_MAX = 6'h3b;
  localparam logic [5:0]  DSD_MIN_MAX = 6'h3b;
  localparam logic [16:0] DSD_HR_MAX  = 17'h1869f;
  localparam int DSD_SNAP_N = 4;

  typedef struct packed {
    logic [16:0] hours;
    logic [5:0]  minutes;
    logic [5:0]  seconds;
    logic [9:0]  millis;
  } dsd_time_s;

  typedef struct packed {
    dsd_time_s   elapsed;
    logic [15:0] ctrl_status;
    logic [15:0] warn_status;
    logic        valid;
  } dsd_snap_s;

  typedef struct packed {
    logic dc_ctrl_rise_phase;
    logic below_shutdown_threshold;
    logic mains_fail_regulation;
    logic dc_link_overvolt_limit;
    logic boost;
    logic current_limit;
    logic torque_limit;
    logic ctrl_switch;
    logic start_limit;
    logic long_overload_limit;
    logic short_overload_limit;
    logic heatsink_limit;
    logic motor_temp_limit;
    logic freq_limit;
  } dsd_limit_s;

  typedef struct packed {
    logic run;
    logic warn;
    logic fault;
  } dsd_panel_s;

endpackage : dsd_pkg

// ### verification/dsd_led_obs.sv
// ============================================================================
// Lamp watcher: classifies each lamp as off, steady or flashing
module dsd_led_obs (
  input  wire logic         sys_clk,
  input  wire logic         obs_clr,
  input  wire logic [4:0]   lamps,
  output dsd_pkg::dsd_pat_e pat [5]
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [4:0] seen_hi_r;
  logic [4:0] seen_lo_r;
  // Window must span two flash half periods or a flash reads steady
  always_ff @(posedge sys_clk) begin
    if (obs_clr) begin
      seen_hi_r <= 5'h00;
      seen_lo_r <= 5'h00;
    end else begin
      seen_hi_r <= seen_hi_r | lamps;
      seen_lo_r <= seen_lo_r | ~lamps;
    end
  end
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (seen_hi_r[i] && seen_lo_r[i]) pat[i] = dsd_pkg::DSD_PAT_FLASH;
      else if (seen_hi_r[i]) pat[i] = dsd_pkg::DSD_PAT_ON;
      else pat[i] = dsd_pkg::DSD_PAT_OFF;
    end
  end
endmodule // dsd_led_obs

// ### verification/testbench.sv
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin bad_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
// ============================================================================
// Self-checking bench
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [13:0] lim;  logic [5:0] din; logic mi; logic mm; logic [1:0] dq;
    logic mo; logic mom; logic [1:0] mode; logic [15:0] cs; logic [6:0] di; logic [2:0] qo;
  } dsd_vec_s;
  typedef struct packed {
    dsd_pkg::dsd_opstate_e st; logic wr;
    dsd_pkg::dsd_pat_e g; dsd_pkg::dsd_pat_e r;
    dsd_pkg::dsd_pat_e pr; dsd_pkg::dsd_pat_e pw; dsd_pkg::dsd_pat_e pf;
  } dsd_lamp_s;
  localparam dsd_pkg::dsd_pat_e PO = dsd_pkg::DSD_PAT_OFF;
  localparam dsd_pkg::dsd_pat_e PN = dsd_pkg::DSD_PAT_ON;
  localparam dsd_pkg::dsd_pat_e PF = dsd_pkg::DSD_PAT_FLASH;
  logic sys_clk, rst_b, warn_present, panel_attached, mfi, mfi_m, mfo, mfo_m;
  logic release_en, fault_event, store_abort, obs_clr, led_green, led_red, snap_ok;
  logic [1:0]  ctrl_status_mode, dout_level, snap_sel;
  logic [5:0]  din_level;
  logic [15:0] warn_status, ctrl_status_led, ctrl_status_panel, ctrl_status;
  logic [6:0]  din_status;
  logic [2:0]  dout_status;
  dsd_pkg::dsd_opstate_e op_state;
  dsd_pkg::dsd_limit_s   limits;
  dsd_pkg::dsd_panel_s   panel;
  dsd_pkg::dsd_snap_s    snap_out;
  dsd_pkg::dsd_pat_e     pat [5];
  int bad_count, samples_checked;
  dsd_vec_s  vec_tab [5];
  dsd_lamp_s lamp_tab [8];

  dsd_encoder #(.FLASH_CYC(4), .MS_CYC(2)) dsd_encoder_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .op_state(op_state), .warn_present(warn_present),
    .panel_attached(panel_attached), .ctrl_status_mode(ctrl_status_mode), .limits(limits),
    .din_level(din_level), .multifunction_input_one(mfi), .mfi_digital_mode(mfi_m),
    .dout_level(dout_level), .multifunction_output_one(mfo), .mfo_digital_mode(mfo_m),
    .release_en(release_en), .warn_status(warn_status), .fault_event(fault_event),
    .store_abort(store_abort), .snap_sel(snap_sel), .led_green(led_green),
    .led_red(led_red), .panel(panel), .ctrl_status_led(ctrl_status_led),
    .ctrl_status_panel(ctrl_status_panel), .din_status(din_status),
    .dout_status(dout_status), .ctrl_status(ctrl_status), .snap_out(snap_out),
    .snap_ok(snap_ok));
  dsd_led_obs dsd_led_obs_i (.sys_clk(sys_clk), .obs_clr(obs_clr),
    .lamps({led_green, led_red, panel.run, panel.warn, panel.fault}), .pat(pat));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // ==========================================================================
  // Helpers
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask
  task automatic fault(input logic [15:0] ws, input logic ab);
    fault_event = 1'b1;
    warn_status = ws;
    store_abort = ab;
    tick();
    fault_event = 1'b0;
    store_abort = 1'b0;
    // Let an edge pass so back-to-back faults never retoggle in one step
    tick();
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #100us;
    bad_count++;
    test_done();
  end
  // ==========================================================================
  // Main sequence
  initial begin
    rst_b = 1'b0; op_state = dsd_pkg::DSD_RUN; warn_present = 1'b0; panel_attached = 1'b1;
    ctrl_status_mode = 2'h3; limits = 14'h3fff; din_level = 6'h3f; mfi = 1'b0; mfi_m = 1'b0;
    dout_level = 2'h3; mfo = 1'b0; mfo_m = 1'b0; release_en = 1'b0; warn_status = 16'h0000;
    fault_event = 1'b0; store_abort = 1'b0; snap_sel = 2'h0; obs_clr = 1'b0;
    vec_tab = '{'{14'h0000, 6'h21, 0, 0, 2'h1, 0, 0, 2'h3, 16'h0000, 7'h21, 3'h1},
                '{14'h0900, 6'h3f, 1, 1, 2'h3, 1, 1, 2'h3, 16'h0024, 7'h7f, 3'h7},
                '{14'h3fff, 6'h00, 1, 0, 2'h0, 1, 0, 2'h2, 16'h3fff, 7'h00, 3'h0},
                '{14'h2001, 6'h15, 0, 1, 2'h2, 0, 1, 2'h1, 16'h2001, 7'h15, 3'h2},
                '{14'h0400, 6'h2a, 1, 1, 2'h1, 1, 1, 2'h0, 16'h0008, 7'h6a, 3'h5}};
    lamp_tab = '{'{dsd_pkg::DSD_OFF, 0, PO, PO, PO, PO, PO},
                 '{dsd_pkg::DSD_INIT, 0, PN, PN, PO, PO, PO},
                 '{dsd_pkg::DSD_READY, 0, PF, PO, PF, PO, PO},
                 '{dsd_pkg::DSD_RUN, 0, PN, PO, PN, PO, PO},
                 '{dsd_pkg::DSD_RUN, 1, PN, PF, PN, PN, PO},
                 '{dsd_pkg::DSD_READY, 1, PF, PF, PN, PN, PO},
                 '{dsd_pkg::DSD_FAULT_LAST, 0, PO, PF, PO, PO, PF},
                 '{dsd_pkg::DSD_FAULT_ACK, 0, PO, PN, PO, PO, PN}};
    repeat (5) tick();
    `CHK({led_green, led_red, ctrl_status, din_status}, 25'h0)
    `CHK(snap_ok, 1'b1)
    rst_b = 1'b1;
    // Ordinary vectors: packing, summing and display routing
    foreach (vec_tab[k]) begin
      limits = vec_tab[k].lim; din_level = vec_tab[k].din; mfi = vec_tab[k].mi;
      mfi_m = vec_tab[k].mm; dout_level = vec_tab[k].dq; mfo = vec_tab[k].mo;
      mfo_m = vec_tab[k].mom; ctrl_status_mode = vec_tab[k].mode;
      tick();
      `CHK(ctrl_status, vec_tab[k].cs)
      `CHK(din_status, vec_tab[k].di)
      `CHK(dout_status, vec_tab[k].qo)
      `CHK(ctrl_status_led, vec_tab[k].mode[1] ? vec_tab[k].cs : 16'h0000)
      `CHK(ctrl_status_panel, vec_tab[k].mode[0] ? vec_tab[k].cs : 16'h0000)
    end
    // Every limiting function alone gives its own code bit
    for (int i = 0; i < 14; i++) begin
      limits = 14'h2000 >> i;
      tick();
      `CHK(ctrl_status, 16'h0001 << i)
    end
    // Indicator and panel patterns per operating state
    foreach (lamp_tab[k]) begin
      op_state = lamp_tab[k].st;
      warn_present = lamp_tab[k].wr;
      repeat (3) tick();
      obs_clr = 1'b1;
      tick();
      obs_clr = 1'b0;
      repeat (20) tick();
      `CHK({pat[4], pat[3]}, {lamp_tab[k].g, lamp_tab[k].r})
      `CHK({pat[2], pat[1], pat[0]}, {lamp_tab[k].pr, lamp_tab[k].pw, lamp_tab[k].pf})
    end
    panel_attached = 1'b0;
    ctrl_status_mode = 2'h1;
    repeat (2) tick();
    `CHK(panel, 3'h0)
    `CHK(ctrl_status_panel, 16'h0000)
    // Snapshots: capture, history order, integrity flag, elapsed time
    limits = 14'h0900;
    repeat (2) tick();
    fault(16'h0011, 1'b0);
    `CHK({snap_out.ctrl_status, snap_out.warn_status, snap_out.valid}, {16'h0024, 16'h0011, 1'b1})
    `CHK(snap_out.elapsed, 39'h0)
    `CHK(snap_ok, 1'b1)
    release_en = 1'b1;
    repeat (20) tick();
    fault(16'h0022, 1'b0);
    `CHK(snap_out.elapsed.millis inside {[10'h9 : 10'hb]}, 1'b1)
    `CHK({snap_out.elapsed.hours, snap_out.elapsed.seconds}, 23'h0)
    fault(16'h0033, 1'b1);
    `CHK(snap_ok, 1'b0)
    `CHK(snap_out.valid, 1'b0)
    fault(16'h0044, 1'b0);
    `CHK(snap_ok, 1'b1)
    `CHK(snap_out.warn_status, 16'h0044)
    snap_sel = 2'h2;
    #1;
    `CHK(snap_out.warn_status, 16'h0022)
    snap_sel = 2'h3;
    #1;
    `CHK(snap_out.warn_status, 16'h0011)
    fault(16'h0055, 1'b0);
    `CHK(snap_out.warn_status, 16'h0022)
    // Second rollover needs a thousand ms ticks
    snap_sel = 2'h0;
    release_en = 1'b0;
    repeat (2) tick();
    release_en = 1'b1;
    repeat (2010) tick();
    fault(16'h0066, 1'b0);
    `CHK(snap_out.elapsed.seconds, 6'h01)
    `CHK(snap_out.elapsed.millis <= 10'h6, 1'b1)
    test_done();
  end
endmodule // testbench
